// ===== positioning_status_flags.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module positioning_status_flags
    import pos_status_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire logic [7:0]            regAddr,
    input  wire logic [15:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [15:0]           regRdata,
    // Module events
    input  wire logic                  bootDone,
    // Per-axis inputs: events one bit per axis, opKind four bits and error words 16 bits per axis
    input  wire logic [AXES-1:0]       startCmd,
    input  wire logic [AXES-1:0]       tableStart,
    input  wire logic [AXES-1:0]       tableDone,
    input  wire logic [AXES-1:0]       motionDone,
    input  wire logic [AXES-1:0]       stopEnded,
    input  wire logic [AXES-1:0]       remainStandby,
    input  wire logic [AXES-1:0]       remainCancel,
    input  wire logic [AXES-1:0]       auxOn,
    input  wire logic [AXES-1:0]       auxOffCmd,
    input  wire logic [AXES-1:0]       servoXfrBusy,
    input  wire logic [AXES-1:0]       speedCmd,
    input  wire logic [AXES-1:0]       speedDone,
    input  wire logic [AXES-1:0]       targetCmd,
    input  wire logic [AXES-1:0]       targetDone,
    input  wire logic [AXES-1:0]       positioning,
    input  wire logic [AXES-1:0]       errDetect,
    input  wire logic [AXES-1:0]       servoErr,
    input  wire logic [AXES-1:0]       errResetCmd,
    input  wire logic [AXES*4-1:0]     opKind,
    input  wire logic [AXES*16-1:0]    errCodeIn,
    input  wire logic [AXES*16-1:0]    errWordIn,
    input  wire logic [AXES*16-1:0]    srvNumIn,
    // Shared buffer activity
    input  wire logic                  flashBusy,
    input  wire logic                  initBusy,
    // Servo indication
    output logic      [AXES-1:0]       servoStatus
);
    // Events of one axis, gathered from the per-axis vectors
    typedef struct packed {
        logic       start;
        logic       tableStart;
        logic       tableDone;
        logic       motionDone;
        logic       stopEnded;
        logic       remainStandby;
        logic       remainCancel;
        logic       auxOn;
        logic       auxOff;
        logic       servoXfr;
        logic       speedCmd;
        logic       speedDone;
        logic       targetCmd;
        logic       targetDone;
        logic       positioning;
        logic       errDetect;
        logic       servoErr;
        logic       errReset;
        logic [3:0] op;
    } axis_events_t;

    // All registered state
    typedef struct packed {
        axis_state_t [AXES-1:0] ax;
        logic                   ready;
        logic [15:0]            rdata;
        logic [AXES-1:0]        srvInd;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    // Flag whose set event outranks its clear event
    function automatic logic set_wins(input logic cur, input logic setEv, input logic clrEv);
        logic res;
        res = cur;
        if (clrEv) begin
            res = 1'b0;
        end
        if (setEv) begin
            res = 1'b1;
        end
        set_wins = res;
    endfunction

    // Flag whose clear event outranks its set event
    function automatic logic clear_wins(input logic cur, input logic setEv, input logic clrEv);
        logic res;
        res = cur;
        if (setEv) begin
            res = 1'b1;
        end
        if (clrEv) begin
            res = 1'b0;
        end
        clear_wins = res;
    endfunction

    // Module or servo fault on one axis
    function automatic logic fault_now(input axis_events_t ev);
        fault_now = ev.errDetect | ev.servoErr;
    endfunction

    // Normal finish of a kind that reports completion; a stop never counts
    function automatic logic done_event(input axis_events_t ev);
        logic normal;
        normal     = ev.motionDone & ~ev.stopEnded;
        done_event = normal & op_reports_done(ev.op);
    endfunction

    // Next status word of one axis
    function automatic logic [15:0] next_status(
        input logic [15:0]  cur,
        input axis_events_t ev,
        input logic         ready,
        input logic         flash,
        input logic         init
    );
        logic [15:0] s;
        logic        fault;
        s     = cur;
        fault = fault_now(ev);
        // Completion, clear outranks set
        s[BIT_DONE]   = clear_wins(cur[BIT_DONE], done_event(ev),
                                   ev.start | fault | ev.errReset);
        s[BIT_REMAIN] = set_wins(cur[BIT_REMAIN], ev.remainStandby,
                                 ev.start | ev.remainCancel);
        s[BIT_AUX]    = set_wins(cur[BIT_AUX], ev.auxOn, ev.auxOff);
        s[BIT_SPEED]  = set_wins(cur[BIT_SPEED], ev.speedCmd & ev.positioning,
                                 ev.speedDone);
        s[BIT_TARGET] = set_wins(cur[BIT_TARGET], ev.targetCmd & ev.positioning,
                                 ev.targetDone);
        s[BIT_TABLE]  = set_wins(cur[BIT_TABLE], ev.start & ev.tableStart,
                                 ev.tableDone);
        s[BIT_ERROR]  = set_wins(cur[BIT_ERROR], fault, ev.errReset);
        // Level indications follow their sources
        s[BIT_SERVO_XFR] = ev.servoXfr;
        s[BIT_FLASH]     = flash;
        s[BIT_INIT]      = init;
        s[BIT_READY]     = ready;
        next_status = s;
    endfunction

    // Read decode over both axes
    function automatic logic [15:0] read_word(input logic [7:0] addr, input state_t st);
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            OFS_X_STATUS: begin
                w = st.ax[0].status;
            end
            OFS_X_ERROR: begin
                w = st.ax[0].errCode;
            end
            OFS_X_ERRWORD: begin
                w = st.ax[0].errWord;
            end
            OFS_X_SRVNUM: begin
                w = st.ax[0].srvNum;
            end
            OFS_Y_STATUS: begin
                w = st.ax[1].status;
            end
            OFS_Y_ERROR: begin
                w = st.ax[1].errCode;
            end
            OFS_Y_ERRWORD: begin
                w = st.ax[1].errWord;
            end
            OFS_Y_SRVNUM: begin
                w = st.ax[1].srvNum;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        read_word = w;
    endfunction

    always_comb begin
        axis_events_t ev;
        logic         fault;
        ev        = '0;
        fault     = 1'b0;
        nxt_state = state_ff;
        // Boot completion is sticky until reset
        if (bootDone) begin
            nxt_state.ready = 1'b1;
        end
        for (int i = 0; i < AXES; i++) begin
            ev.start         = startCmd[i];
            ev.tableStart    = tableStart[i];
            ev.tableDone     = tableDone[i];
            ev.motionDone    = motionDone[i];
            ev.stopEnded     = stopEnded[i];
            ev.remainStandby = remainStandby[i];
            ev.remainCancel  = remainCancel[i];
            ev.auxOn         = auxOn[i];
            ev.auxOff        = auxOffCmd[i];
            ev.servoXfr      = servoXfrBusy[i];
            ev.speedCmd      = speedCmd[i];
            ev.speedDone     = speedDone[i];
            ev.targetCmd     = targetCmd[i];
            ev.targetDone    = targetDone[i];
            ev.positioning   = positioning[i];
            ev.errDetect     = errDetect[i];
            ev.servoErr      = servoErr[i];
            ev.errReset      = errResetCmd[i];
            ev.op            = opKind[i*4 +: 4];
            fault            = fault_now(ev);
            nxt_state.ax[i].status = next_status(state_ff.ax[i].status, ev,
                                                 nxt_state.ready, flashBusy, initBusy);
            // Error information captured on every fault
            if (fault) begin
                nxt_state.ax[i].errCode = errCodeIn[i*16 +: 16];
                nxt_state.ax[i].errWord = errWordIn[i*16 +: 16];
                nxt_state.ax[i].srvNum  = srvNumIn[i*16 +: 16];
            end
            nxt_state.srvInd[i] = set_wins(state_ff.srvInd[i], ev.servoErr,
                                           ev.errReset);
        end
        // Reads are side-effect free
        nxt_state.rdata = 16'h0000;
        if (regRd) begin
            nxt_state.rdata = read_word(regAddr, state_ff);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign regRdata    = state_ff.rdata;
    assign servoStatus = state_ff.srvInd;
endmodule

// ===== pos_status_pkg.sv
package pos_status_pkg;
    localparam int          AXES          = 2;
    localparam logic [7:0]  OFS_X_STATUS  = 8'h1C;
    localparam logic [7:0]  OFS_X_ERROR   = 8'h1D;
    localparam logic [7:0]  OFS_X_ERRWORD = 8'h1E;
    localparam logic [7:0]  OFS_X_SRVNUM  = 8'h1F;
    localparam logic [7:0]  OFS_Y_STATUS  = 8'h80;
    localparam logic [7:0]  OFS_Y_ERROR   = 8'h81;
    localparam logic [7:0]  OFS_Y_ERRWORD = 8'h82;
    localparam logic [7:0]  OFS_Y_SRVNUM  = 8'h83;
    localparam int          BIT_ERROR     = 5;
    localparam int          BIT_DONE      = 6;
    localparam int          BIT_REMAIN    = 7;
    localparam int          BIT_AUX       = 8;
    localparam int          BIT_READY     = 9;
    localparam int          BIT_SERVO_XFR = 10;
    localparam int          BIT_FLASH     = 11;
    localparam int          BIT_INIT      = 12;
    localparam int          BIT_SPEED     = 13;
    localparam int          BIT_TARGET    = 14;
    localparam int          BIT_TABLE     = 15;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    localparam logic [3:0]  OP_ZERO_DOG   = 4'h0;
    localparam logic [3:0]  OP_ZERO_STOP  = 4'h1;
    localparam logic [3:0]  OP_ZERO_DSET  = 4'h2;
    localparam logic [3:0]  OP_SPEED1     = 4'h3;
    localparam logic [3:0]  OP_FEED1      = 4'h4;
    localparam logic [3:0]  OP_SPEED2     = 4'h5;
    localparam logic [3:0]  OP_FEED2      = 4'h6;
    localparam logic [3:0]  OP_INT_STOP   = 4'h7;
    localparam logic [3:0]  OP_MULTI      = 4'h8;
    localparam logic [3:0]  OP_LINEAR     = 4'h9;
    localparam logic [3:0]  OP_LIN_INT    = 4'hA;
    localparam logic [3:0]  OP_CIRCULAR   = 4'hB;
    localparam logic [3:0]  OP_RECIP      = 4'hC;
    localparam logic [3:0]  OP_JOG        = 4'hD;
    localparam logic [3:0]  OP_MPG        = 4'hE;
    localparam logic [3:0]  OP_VARSPEED   = 4'hF;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] errCode;
        logic [15:0] errWord;
        logic [15:0] srvNum;
    } axis_state_t;

    // Operation kinds that report normal completion
    function automatic logic op_reports_done(input logic [3:0] op);
        case (op)
            OP_ZERO_DSET, OP_JOG, OP_MPG, OP_VARSPEED: op_reports_done = 1'b0;
            default:                                    op_reports_done = 1'b1;
        endcase
    endfunction
endpackage

// ===== positioning_status_flags_properties.sv
`timescale 1ns/1ps
module positioning_status_flags_properties
    import pos_status_pkg::*;
(
    // Watched ports
    input wire logic            core_clk,
    input wire logic            sys_rst,
    input wire logic [7:0]      regAddr,
    input wire logic            regRd,
    input wire logic [15:0]     regRdata,
    input wire logic            bootDone,
    input wire logic            flashBusy,
    input wire logic [AXES-1:0] startCmd,
    input wire logic [AXES-1:0] errDetect,
    input wire logic [AXES-1:0] servoErr,
    input wire logic [AXES-1:0] errResetCmd,
    input wire logic [AXES-1:0] servoStatus
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire rdX = regRd && regAddr == OFS_X_STATUS;
    wire rdY = regRd && regAddr == OFS_Y_STATUS;
    unmapped_zero_a: assert property (regRd && regAddr == 8'h00 |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
    ready_seen_a: assert property (bootDone ##1 rdX |=> regRdata[BIT_READY])
        else $error("ready missing");
    done_clear_a: assert property (startCmd[0] ##1 rdX |=> !regRdata[BIT_DONE])
        else $error("done kept after start");
    error_set_a: assert property (errDetect[0] ##1 rdX |=> regRdata[BIT_ERROR])
        else $error("error bit missing");
    flash_mirror_a: assert property (rdY && !$past(sys_rst) |=>
        regRdata[BIT_FLASH] == $past(flashBusy, 2))
        else $error("flash bit wrong");
    servo_set_a: assert property (servoErr[0] |=> servoStatus[0])
        else $error("servo status missing");
    servo_clear_a: assert property (errResetCmd[0] && !servoErr[0] |=> !servoStatus[0])
        else $error("servo status kept");
    servo_hold_a: assert property (servoStatus[0] && !errResetCmd[0] |=> servoStatus[0])
        else $error("servo status lost");
    cover property (rdX ##1 regRdata[BIT_DONE]);
    cover property (rdY ##1 regRdata[BIT_ERROR]);
    cover property (servoStatus[1]);
endmodule

bind positioning_status_flags positioning_status_flags_properties chk (.core_clk, .sys_rst,
    .regAddr, .regRd, .regRdata, .bootDone, .flashBusy, .startCmd, .errDetect, .servoErr,
    .errResetCmd, .servoStatus);

// ===== host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
    // Bus toward the block
    input  wire logic        core_clk,
    output logic [7:0]       regAddr,
    output logic [15:0]      regWdata,
    output logic             regWr,
    output logic             regRd,
    input  wire logic [15:0] regRdata
);
    initial begin
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Idle address shows the inverse of the last value; idle data does so only after a write
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        @(posedge core_clk);
        d = regRdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~v;
    endtask
endmodule

// ===== positioning_status_flags_bench.sv
`timescale 1ns/1ps
module positioning_status_flags_bench;
    import pos_status_pkg::*;
    logic            core_clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            bootDone = 1'b0;
    logic            flashBusy = 1'b0;
    logic            initBusy = 1'b0;
    logic [7:0]      opKind = 8'h00;
    logic [31:0]     errCodeIn = 32'h0, errWordIn = 32'h0, srvNumIn = 32'h0;
    logic [AXES-1:0] e [18];
    logic [AXES-1:0] servoStatus;
    logic [7:0]      regAddr, b;
    logic [15:0]     regWdata, regRdata, d, x;
    logic            regWr, regRd;
    int st [2], errTotal = 0, totalChecks = 0, cyc = 0;
    int sk [4] = '{7, 10, 12, 0};
    int sj [4] = '{-1, 14, 14, 1};
    int ck [4] = '{8, 11, 13, 2};
    positioning_status_flags dut (.core_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .bootDone, .startCmd(e[0]), .tableStart(e[1]), .tableDone(e[2]),
        .motionDone(e[3]), .stopEnded(e[4]), .remainStandby(e[5]), .remainCancel(e[6]),
        .auxOn(e[7]), .auxOffCmd(e[8]), .servoXfrBusy(e[9]), .speedCmd(e[10]),
        .speedDone(e[11]), .targetCmd(e[12]), .targetDone(e[13]), .positioning(e[14]),
        .errDetect(e[15]), .servoErr(e[16]), .errResetCmd(e[17]), .opKind, .errCodeIn,
        .errWordIn, .srvNumIn, .flashBusy, .initBusy, .servoStatus);
    host_bus_model host (.core_clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    initial forever #5 core_clk = ~core_clk;
    task automatic printVerdict();
        $display("checks %0d errors %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errTotal++;
            printVerdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] xp);
        totalChecks++;
        if (s !== xp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", n, xp, s);
        end
    endtask
    task automatic fire(input int a, input int k, input int j = -1);
        e[k][a] <= 1'b1;
        if (j >= 0) e[j][a] <= 1'b1;
        @(posedge core_clk);
        e[k][a] <= 1'b0;
        if (j >= 0) e[j][a] <= 1'b0;
    endtask
    task automatic cs(input int a);
        host.rd(a ? OFS_Y_STATUS : OFS_X_STATUS, d);
        chk("status", d, 16'(st[a]));
    endtask
    initial begin
        foreach (e[i]) e[i] = '0;
        void'($urandom(63));
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int r = 0; r < 4; r++) begin
            host.rd(OFS_X_STATUS + 8'(r), d);
            chk("reset", d, 16'h0000);
        end
        bootDone <= 1'b1;
        @(posedge core_clk);
        bootDone <= 1'b0;
        st = '{32'h200, 32'h200};
        cs(0);
        for (int a = 0; a < 2; a++) begin
            b = a ? OFS_Y_STATUS : OFS_X_STATUS;
            for (int op = 0; op < 16; op++) begin
                opKind[a*4 +: 4] <= 4'(op);
                fire(a, 0);
                st[a] &= ~32'hC0;
                cs(a);
                fire(a, 3);
                if (!(op inside {2, 13, 14, 15})) st[a] |= 32'h40;
                cs(a);
            end
            opKind[a*4 +: 4] <= OP_SPEED1;
            fire(a, 0);
            fire(a, 3, 4);
            st[a] &= ~32'hC0;
            cs(a);
            fire(a, 5);
            st[a] |= 32'h80;
            cs(a);
            fire(a, 6);
            st[a] &= ~32'h80;
            cs(a);
            for (int t = 0; t < 4; t++) begin
                fire(a, sk[t], sj[t]);
                st[a] |= 1 << (8 + (t ? t + 4 : 0));
                cs(a);
                fire(a, ck[t]);
                st[a] &= ~(1 << (8 + (t ? t + 4 : 0)));
                cs(a);
            end
            flashBusy <= 1'b1;
            initBusy <= 1'b1;
            fire(a, 9);
            flashBusy <= 1'b0;
            initBusy <= 1'b0;
            st[a] |= 32'h1C00;
            cs(a);
            st[a] &= ~32'h1C00;
            cs(a);
            x = 16'($urandom_range(9999));
            errCodeIn[a*16 +: 16] <= x;
            errWordIn[a*16 +: 16] <= ~x;
            srvNumIn[a*16 +: 16] <= x ^ 16'h00FF;
            fire(a, 3);
            fire(a, 15, 16);
            st[a] = (st[a] | 32'h20) & ~32'h40;
            cs(a);
            for (int r = 1; r < 4; r++) begin
                host.rd(b + 8'(r), d);
                chk("errinfo", d, r == 1 ? x : r == 2 ? ~x : x ^ 16'h00FF);
            end
            chk("servo", 16'(servoStatus[a]), 16'h0001);
            fire(a, 17);
            st[a] &= ~32'h20;
            cs(a);
            chk("servo", 16'(servoStatus[a]), 16'h0000);
        end
        host.wr(OFS_X_STATUS, 16'hFFFF);
        cs(0);
        cs(1);
        host.rd(8'h00, d);
        chk("unmapped", d, 16'h0000);
        printVerdict();
    end
endmodule
